// ===== rpt_ctrl.sv
// Controller beside a level-translating bus repeater: drives its enable pin
// and takes part on the port B segment as an open-drain node.
// Assumes all pin inputs are synchronous to ref_clk_i and pull-ups exist.
`timescale 1ns/1ps
module rpt_ctrl #(
	parameter int IDLE_COUNT = rpt_pkg::IDLE_CYCLES
)(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// User requests
	input wire logic en_req_i,
	input wire logic drv_scl_req_i,
	input wire logic drv_sda_req_i,
	// Observed line levels, both segments
	input wire logic scl_a_i,
	input wire logic sda_a_i,
	input wire logic scl_b_i,
	input wire logic sda_b_i,
	// Repeater enable pin
	output logic en_o,
	// Port B open-drain drive
	output logic scl_b_o,
	output logic scl_b_oe_o,
	output logic sda_b_o,
	output logic sda_b_oe_o,
	// Status
	output logic pending_o,
	output logic idle_o
);
	// Refused at elaboration: a zero count would call a busy bus idle
	if (IDLE_COUNT < 1)
	begin
		$error("IDLE_COUNT must be at least one");
	end

	// A drive already running may finish; only a new one is held back
	function automatic logic drive_next(input logic req, input logic driving,
		input logic held);
		drive_next = req && (driving || !held);
	endfunction

	rpt_pkg::rpt_state_t state_reg;
	rpt_pkg::rpt_state_t state_next;
	logic en_reg;
	logic en_next;
	logic scl_oe_reg;
	logic scl_oe_next;
	logic sda_oe_reg;
	logic sda_oe_next;
	logic pend_reg;
	logic pend_next;
	logic scl_lvl_reg;
	logic scl_lvl_next;
	logic sda_lvl_reg;
	logic sda_lvl_next;
	logic lines_high;
	logic idle;

	// Own drive counts as busy, so enable never flips under our own transfer;
	// both segments are watched, so star or chained repeaters read as busy too
	assign lines_high = scl_a_i & sda_a_i & scl_b_i & sda_b_i // RULE7 RULE8
		& ~scl_oe_reg & ~sda_oe_reg; // RULE14

	// The long all-high wait outlasts any pull-up rise and turnaround bounce
	rpt_idle_det #(
		.COUNT(IDLE_COUNT)
	) u_idle (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.lines_high_i(lines_high), // RULE17
		.idle_o(idle)
	);

	always_comb
	begin
		state_next = state_reg;
		en_next = en_reg;
		unique case (state_reg)
			rpt_pkg::RPT_STABLE:
			begin
				if (en_req_i != en_reg)
					state_next = rpt_pkg::RPT_WAIT_IDLE;
			end
			rpt_pkg::RPT_WAIT_IDLE:
			begin
				if (en_req_i == en_reg)
					state_next = rpt_pkg::RPT_STABLE;
				else if (idle && lines_high)
				begin
					en_next = en_req_i; // RULE14
					state_next = rpt_pkg::RPT_STABLE;
				end
			end
		endcase
		pend_next = (state_next == rpt_pkg::RPT_WAIT_IDLE);
		// No new drive starts while an enable change waits; a running one may finish
		scl_oe_next = drive_next(drv_scl_req_i, scl_oe_reg, pend_reg); // RULE14 RULE20
		sda_oe_next = drive_next(drv_sda_req_i, sda_oe_reg, pend_reg); // RULE14 RULE20
		// Full ground low, never high: the pull-up makes the high level
		scl_lvl_next = rpt_pkg::LINE_LOW; // RULE16 RULE18 RULE19 RULE5
		sda_lvl_next = rpt_pkg::LINE_LOW; // RULE16 RULE18 RULE19 RULE5
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_reg <= rpt_pkg::RPT_STABLE;
			en_reg <= rpt_pkg::EN_RESET;
			scl_oe_reg <= 1'h0;
			sda_oe_reg <= 1'h0;
			pend_reg <= 1'h0;
			scl_lvl_reg <= rpt_pkg::LINE_LOW;
			sda_lvl_reg <= rpt_pkg::LINE_LOW;
		end
		else
		begin
			state_reg <= state_next;
			en_reg <= en_next;
			scl_oe_reg <= scl_oe_next;
			sda_oe_reg <= sda_oe_next;
			pend_reg <= pend_next;
			scl_lvl_reg <= scl_lvl_next;
			sda_lvl_reg <= sda_lvl_next;
		end
	end

	assign scl_b_o = scl_lvl_reg;
	assign sda_b_o = sda_lvl_reg;
	assign en_o = en_reg;
	assign scl_b_oe_o = scl_oe_reg;
	assign sda_b_oe_o = sda_oe_reg;
	assign pending_o = pend_reg;
	assign idle_o = idle;

	sequence s_change_ready;
		pending_o && (en_req_i != en_o) && idle && lines_high;
	endsequence

	sequence s_change_held;
		(en_req_i != en_o) && !(idle && lines_high);
	endsequence

	sequence s_scl_running;
		scl_b_oe_o && drv_scl_req_i;
	endsequence

	sequence s_sda_running;
		sda_b_oe_o && drv_sda_req_i;
	endsequence

	AST_EN_ONLY_IDLE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$changed(en_o) |-> $past(idle) && $past(lines_high)) // RULE14
		else $error("enable changed while bus busy");

	AST_EN_FROM_WAIT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$changed(en_o) |-> $past(pending_o)) // RULE14
		else $error("enable changed without a pending request");

	AST_EN_APPLIED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		s_change_ready |=> (en_o == $past(en_req_i)) && !pending_o) // RULE14
		else $error("idle bus did not take enable change");

	AST_PEND_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(en_req_i != en_o) && !(idle && lines_high) |=> pending_o) // RULE14
		else $error("pending not raised for enable change");

	AST_PEND_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		s_change_held |=> $stable(en_o)) // RULE14
		else $error("enable moved before the bus was idle");

	AST_PEND_WITHDRAW: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		pending_o && (en_req_i == en_o) |=> !pending_o) // RULE14
		else $error("pending kept after request withdrawn");

	AST_PEND_ONLY_DIFF: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		pending_o |-> $past(en_req_i != en_o)) // RULE14
		else $error("pending without a differing request");

	AST_OWN_BUSY: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		scl_b_oe_o || sda_b_oe_o |=> !idle_o) // RULE14
		else $error("idle reported under own drive");

	AST_IDLE_AFTER_HIGH: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		idle_o |-> $past(lines_high)) // RULE14
		else $error("idle reported after a low line");

	AST_SCL_NO_START: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(scl_b_oe_o) |-> !$past(pending_o) && $past(drv_scl_req_i)) // RULE14
		else $error("clock drive began during pending change");

	AST_SDA_NO_START: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(sda_b_oe_o) |-> !$past(pending_o) && $past(drv_sda_req_i)) // RULE14
		else $error("data drive began during pending change");

	AST_SCL_HELD_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		pending_o && !scl_b_oe_o |=> !scl_b_oe_o) // RULE14
		else $error("clock drive started while change pending");

	AST_SDA_HELD_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		pending_o && !sda_b_oe_o |=> !sda_b_oe_o) // RULE14
		else $error("data drive started while change pending");

	AST_SCL_KEEP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		s_scl_running |=> scl_b_oe_o) // RULE14 RULE20
		else $error("running clock drive cut short");

	AST_SDA_KEEP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		s_sda_running |=> sda_b_oe_o) // RULE14 RULE20
		else $error("running data drive cut short");

	AST_RELEASE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!drv_scl_req_i && !drv_sda_req_i |=> !scl_b_oe_o && !sda_b_oe_o) // RULE16
		else $error("line not released to pull-up");

	AST_SCL_RELEASE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!drv_scl_req_i |=> !scl_b_oe_o) // RULE16 RULE20
		else $error("clock line not released to pull-up");

	AST_SDA_RELEASE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!drv_sda_req_i |=> !sda_b_oe_o) // RULE16 RULE20
		else $error("data line not released to pull-up");

	AST_EN_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		scl_b_oe_o |=> $stable(en_o)) // RULE14
		else $error("enable moved under own drive");

	AST_SDA_EN_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		sda_b_oe_o |=> $stable(en_o)) // RULE14
		else $error("enable moved under own data drive");
endmodule

// ===== rpt_pkg.sv
// Constants shared by the repeater-side controller and its idle detector.
// Assumes a 20 MHz reference clock and pins already synchronous to it.
// Overview of operation
// [RULE1] Repeater waits for supplies and references.
// [RULE2] Repeater disables on low-side overvoltage.
// [RULE3] Port B drives offset low, ignores it.
// [RULE4] Repeater ignores its own port B low.
// [RULE5] Never join two offset-low port B sides.
// [RULE6] Port A drives near ground, 0.35 threshold.
// [RULE7] Port A may be starred with buffers.
// [RULE8] Chain only port A to port B.
// [RULE9] Port A low turns on port B pull-down.
// [RULE10] Port A high releases port B pull-down.
// [RULE11] Port B below 0.4V pulls port A.
// [RULE12] Own pull-down holds port B at offset.
// [RULE13] Enable active high, pulled up by default.
// [RULE14] Change enable only while buses idle.
// [RULE15] Enable toggling keeps reference delay untouched.
// [RULE16] Pull-ups required; lines only pulled low.
// [RULE17] Port B pull-up RC at least 67.5 ns.
// [RULE18] Port B drivers must reach 0.4V or less.
// [RULE19] Pull-up current within 3mA unless 30mA sinks.
// [RULE20] Clock and data channels handled independently.
package rpt_pkg;
	localparam int CLK_PERIOD_NS = 50;
	// Bus must read high this long before it counts as idle
	localparam int IDLE_TIME_NS = 1000;
	localparam int IDLE_CYCLES = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic LINE_LOW = 1'h0;
	localparam logic EN_ACTIVE = 1'h1;
	localparam logic EN_RESET = 1'h1;
	typedef enum logic [0:0] {RPT_STABLE, RPT_WAIT_IDLE} rpt_state_t;
endpackage

// ===== rpt_idle_det.sv
// Bus idle detector: counts consecutive cycles with every line high.
// Assumes lines_high_i is synchronous to ref_clk_i.
`timescale 1ns/1ps
module rpt_idle_det #(
	parameter int COUNT = rpt_pkg::IDLE_CYCLES
)(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Line state
	input wire logic lines_high_i,
	output logic idle_o
);
	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] CNT_MAX = CW'(COUNT);

	// Refused at elaboration: a zero count would make idle immediate
	if (COUNT < 1)
	begin
		$error("COUNT must be at least one");
	end

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic idle_reg;
	logic idle_next;

	always_comb
	begin
		cnt_next = '0;
		if (lines_high_i)
			cnt_next = (cnt_reg == CNT_MAX) ? CNT_MAX : cnt_reg + CW'(1);
		idle_next = lines_high_i && (cnt_next == CNT_MAX);
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cnt_reg <= '0;
			idle_reg <= 1'h0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			idle_reg <= idle_next;
		end
	end

	assign idle_o = idle_reg;

	AST_IDLE_NEEDS_HIGH: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(idle_o) |-> $past(lines_high_i)) // RULE14
		else $error("idle raised without lines high");
	AST_IDLE_DROPS: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!lines_high_i |=> !idle_o) // RULE14
		else $error("idle held after a line went low");
endmodule

// ===== rpt_far_model.sv
// Logic-level repeater model: port A and port B of both channels.
// Assumes supplies good and references settled; pull-ups on every line.
`timescale 1ns/1ps
module rpt_far_model (
	// Enable pin
	input wire logic en_i,
	// Pulls by other parties, bit 0 clock, bit 1 data
	input wire logic [1:0] a_pull_i,
	input wire logic [1:0] b_pull_i,
	// Resolved line levels
	output logic [1:0] a_o,
	output logic [1:0] b_o
);
	logic [1:0] a_drv;
	logic [1:0] b_drv;
	// Power-good taken as met; enable never restarts settling
	always_comb
	begin
		// Own offset low is never sensed, so only outside pulls reach A
		b_drv = {2{en_i}} & a_pull_i;
		a_drv = {2{en_i}} & b_pull_i & ~a_pull_i;
		a_o = ~(a_pull_i | a_drv);
		b_o = ~(b_pull_i | b_drv);
	end
endmodule

// ===== tb_top.sv
// Bench for the repeater controller against the repeater model.
// Assumes rpt_pkg, rpt_ctrl and rpt_far_model are compiled first.
`timescale 1ns/1ps
module tb_top;
	logic ref_clk_i = 1'h0;
	logic rst_b_i = 1'h0;
	logic en_req = 1'h1;
	logic [1:0] drv_req = 2'h0;
	logic [1:0] a_pull = 2'h0;
	logic [1:0] a_lvl;
	logic [1:0] b_lvl;
	logic [1:0] oe;
	logic [1:0] b_val;
	logic en;
	logic pending;
	logic idle;
	int failures = 0;
	int num_checks = 0;
	always #25 ref_clk_i = ~ref_clk_i;
	rpt_ctrl #(.IDLE_COUNT(2)) u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.en_req_i(en_req), .drv_scl_req_i(drv_req[0]), .drv_sda_req_i(drv_req[1]),
		.scl_a_i(a_lvl[0]), .sda_a_i(a_lvl[1]), .scl_b_i(b_lvl[0]), .sda_b_i(b_lvl[1]),
		.en_o(en), .scl_b_o(b_val[0]), .scl_b_oe_o(oe[0]), .sda_b_o(b_val[1]),
		.sda_b_oe_o(oe[1]), .pending_o(pending), .idle_o(idle));
	rpt_far_model u_far (.en_i(en), .a_pull_i(a_pull), .b_pull_i(oe & ~b_val),
		.a_o(a_lvl), .b_o(b_lvl));
	task automatic check(input logic [1:0] seen, input logic [1:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: saw %b expected %b", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	task automatic t_host_drive();
		for (int ch = 0; ch < 2; ch++)
		begin
			drv_req = 2'h1 << ch;
			cyc(2);
			check(oe, 2'h1 << ch);
			check(b_val, 2'h0);
			check(a_lvl, ~(2'h1 << ch));
			drv_req = 2'h0;
			cyc(1);
			check(a_lvl, 2'h3);
		end
	endtask
	task automatic t_a_side();
		for (int ch = 0; ch < 2; ch++)
		begin
			a_pull = 2'h1 << ch;
			cyc(3);
			check(b_lvl, ~(2'h1 << ch));
			check(oe, 2'h0);
			a_pull = 2'h0;
			cyc(1);
			check(b_lvl, 2'h3);
		end
	endtask
	task automatic t_withdraw();
		a_pull = 2'h3;
		en_req = 1'h0;
		cyc(3);
		check({en, pending}, 2'h3);
		en_req = 1'h1;
		cyc(2);
		check({en, pending}, 2'h2);
	endtask
	task automatic t_enable();
		a_pull = 2'h3;
		en_req = 1'h0;
		cyc(10);
		check({en, pending}, 2'h3);
		drv_req = 2'h1;
		cyc(2);
		check(oe, 2'h0);
		drv_req = 2'h0;
		a_pull = 2'h0;
		for (int i = 0; i < 20 && en !== 1'h0; i++)
			cyc(1);
		check({en, pending}, 2'h0);
		check({1'h0, idle}, 2'h1);
		a_pull = 2'h2;
		cyc(2);
		check(b_lvl, 2'h3);
		a_pull = 2'h0;
		en_req = 1'h1;
		cyc(10);
		check({en, pending}, 2'h2);
	endtask
	initial
	begin
		cyc(20);
		check({en, pending}, 2'h2);
		check(oe, 2'h0);
		rst_b_i = 1'h1;
		cyc(2);
		t_host_drive();
		t_a_side();
		t_withdraw();
		t_enable();
		stop_test();
	end
	initial
	begin
		#100000;
		failures++;
		stop_test();
	end
endmodule
